// ### inc/sild_params.svh
// Offsets, field positions, reset values and timing counts for the shutdown detector
`ifndef SILD_PARAMS_SVH
`define SILD_PARAMS_SVH
`define SILD_ADDR_MODE 4'h0
`define SILD_ADDR_STAT 4'h4
`define SILD_ADDR_MASK 4'h8
`define SILD_ADDR_IEN 4'hc
`define SILD_P1_LO 2
`define SILD_P2_LO 4
`define SILD_P3_LO 6
`define SILD_MODE_RST 8'h00
`define SILD_LOW_RUN 16
`define SILD_DIV8 8
`define SILD_DIV16 16
`define SILD_DIV128 128
`endif

// ### inc/sild_pkg.sv
// Types for the shutdown input level detector
package sild_pkg;
  typedef logic [1:0] sild_mode_t;
  typedef struct packed {
    logic shutdown_req_pin3;
    logic shutdown_req_pin2;
    logic shutdown_req_pin1;
  } sild_pins_s;
  typedef enum logic [1:0] {SILD_IDLE, SILD_RESP} sild_bus_e;
endpackage

// ### logic/sild_top.sv
// Shutdown request pin qualifier with AXI4-Lite registers
`include "sild_params.svh"
module sild_top
  import sild_pkg::*;
#(
  parameter int RUN_LEN = `SILD_LOW_RUN
) (
  input wire logic clk,
  input wire logic rst,
  input wire sild_pins_s pins,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic [2:0] accept
);
  initial begin
    if (RUN_LEN < 2 || RUN_LEN > 255) $error("RUN_LEN out of range");
  end

  logic [7:0] mode_reg;
  logic [2:0] stat;
  logic [2:0] mask;
  logic ien;
  logic [6:0] div_cnt;
  logic en8, en16, en128;
  logic [2:0] sync1, sync2, prev;
  logic [2:0] hit;
  logic [7:0] run [3];
  logic aw_got, w_got;
  logic [3:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] wstrb_q;
  logic wr_fire;

  // Free divider; all three rates share one counter
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt <= 7'h00;
      en8 <= 1'b0;
      en16 <= 1'b0;
      en128 <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 7'h01;
      en8 <= (div_cnt[2:0] == 3'h7);
      en16 <= (div_cnt[3:0] == 4'hf);
      en128 <= (div_cnt == 7'h7f);
    end
  end

  // Two flops before any pin logic
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      prev <= 3'h7;
    end else begin
      sync1 <= {pins.shutdown_req_pin3, pins.shutdown_req_pin2, pins.shutdown_req_pin1};
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      sild_mode_t m;
      logic smp;
      assign m = mode_reg[2*g+2 +: 2];
      always_comb begin
        case (m)
          2'b01: smp = en8;
          2'b10: smp = en16;
          2'b11: smp = en128;
          default: smp = 1'b0;
        endcase
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          run[g] <= 8'h00;
          hit[g] <= 1'b0;
        end else begin
          hit[g] <= 1'b0;
          if (m == 2'b00) begin
            run[g] <= 8'h00;
            hit[g] <= prev[g] & ~sync2[g];
          end else if (smp) begin
            if (sync2[g]) begin
              run[g] <= 8'h00;
            end else if (run[g] == 8'(RUN_LEN - 1)) begin
              run[g] <= 8'h00;
              hit[g] <= 1'b1;
            end else begin
              run[g] <= run[g] + 8'h01;
            end
          end
        end
      end
    end
  endgenerate

  assign wr_fire = aw_got && w_got && !s_axi_bvalid;

  // Write channel; address and data in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 4'h0;
      w_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_got && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_got && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q[1:0] == 2'h0 && aw_q <= `SILD_ADDR_IEN) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= `SILD_MODE_RST;
      mask <= 3'h0;
      ien <= 1'b0;
    end else if (wr_fire && wstrb_q[0]) begin
      case (aw_q)
        `SILD_ADDR_MODE: mode_reg <= {w_q[7:2], 2'b00};
        `SILD_ADDR_MASK: mask <= w_q[2:0];
        `SILD_ADDR_IEN: ien <= w_q[0];
        default: ;
      endcase
    end
  end

  // Sticky status; a new hit beats the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      stat <= 3'h0;
    end else if (wr_fire && wstrb_q[0] && aw_q == `SILD_ADDR_STAT) begin
      stat <= (stat & ~w_q[2:0]) | hit;
    end else begin
      stat <= stat | hit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
      accept <= 3'h0;
    end else begin
      irq <= ien && |(stat & mask);
      accept <= hit;
    end
  end

  // Read channel; one outstanding read
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `SILD_ADDR_MODE: s_axi_rdata <= {24'h000000, mode_reg};
          `SILD_ADDR_STAT: s_axi_rdata <= {29'h0, stat};
          `SILD_ADDR_MASK: s_axi_rdata <= {29'h0, mask};
          `SILD_ADDR_IEN: s_axi_rdata <= {31'h0, ien};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  sequence s_fall3;
    prev[2] && !sync2[2] && mode_reg[7:6] == 2'b00;
  endsequence

  AST_EDGE_ACCEPT: assert property (@(posedge clk) disable iff (rst)
    s_fall3 |=> hit[2]) else $error("falling edge not accepted");
  AST_NO_EDGE_HIT: assert property (@(posedge clk) disable iff (rst)
    (mode_reg[7:6] == 2'b00 && !(prev[2] && !sync2[2])) |=> !hit[2])
    else $error("edge mode hit without edge");
  AST_RUN_RESTART: assert property (@(posedge clk) disable iff (rst)
    (mode_reg[3:2] != 2'b00 && sync2[0] && en8 && mode_reg[3:2] == 2'b01) |=> run[0] == 8'h00)
    else $error("high sample did not restart run");
  AST_DIV8_RATE: assert property (@(posedge clk) disable iff (rst)
    en8 |=> !en8 [*7] ##1 en8) else $error("divide by 8 wrong");
  AST_DIV16_RATE: assert property (@(posedge clk) disable iff (rst)
    en16 |-> en8 ##1 !en16) else $error("divide by 16 wrong");
  AST_DIV128_RATE: assert property (@(posedge clk) disable iff (rst)
    en128 |-> en16 && en8) else $error("divide by 128 misaligned");
  AST_LEVEL_HIT: assert property (@(posedge clk) disable iff (rst)
    (hit[0] && mode_reg[3:2] != 2'b00) |-> $past(run[0]) == 8'(RUN_LEN - 1))
    else $error("level hit before full run");
  AST_MODE_RESET: assert property (@(posedge clk)
    $past(rst) |-> mode_reg == 8'h00) else $error("mode not reset");
  AST_P2_FIELD: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && wstrb_q[0] && aw_q == `SILD_ADDR_MODE) |=> mode_reg[5:4] == $past(w_q[5:4]))
    else $error("pin two field not written");
  AST_P1_FIELD: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && wstrb_q[0] && aw_q == `SILD_ADDR_MODE) |=> mode_reg[3:2] == $past(w_q[3:2]))
    else $error("pin one field not written");
  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (rst)
    !ien |=> !irq) else $error("irq while disabled");

  sequence s_irq_cause;
    ien && (|(stat & mask));
  endsequence

  sequence s_mode_write;
    wr_fire && wstrb_q[0] && aw_q == `SILD_ADDR_MODE;
  endsequence

  AST_IRQ_ON: assert property (@(posedge clk) disable iff (rst)
    s_irq_cause |=> irq) else $error("irq missing while enabled");
  // accept mirrors hit one cycle on
  AST_ACCEPT_PULSE: assert property (@(posedge clk) disable iff (rst)
    |hit |=> accept == $past(hit)) else $error("accept does not follow hit");
  AST_STAT_SET: assert property (@(posedge clk) disable iff (rst)
    |hit |=> (stat & $past(hit)) == $past(hit)) else $error("status lost a hit");
  AST_P3_FIELD: assert property (@(posedge clk) disable iff (rst)
    s_mode_write |=> mode_reg[7:6] == $past(w_q[7:6]))
    else $error("pin three field not written");
  AST_LOW_BITS: assert property (@(posedge clk) disable iff (rst)
    mode_reg[1:0] == 2'b00) else $error("unused mode bits set");
  // pin two needs a full run
  AST_LEVEL_HIT2: assert property (@(posedge clk) disable iff (rst)
    (hit[1] && mode_reg[5:4] != 2'b00) |-> $past(run[1]) == 8'(RUN_LEN - 1))
    else $error("pin two hit before full run");
  // pin three needs a full run
  AST_LEVEL_HIT3: assert property (@(posedge clk) disable iff (rst)
    (hit[2] && mode_reg[7:6] != 2'b00) |-> $past(run[2]) == 8'(RUN_LEN - 1))
    else $error("pin three hit before full run");
  // count never passes the run length
  AST_RUN_BOUND: assert property (@(posedge clk) disable iff (rst)
    run[1] <= 8'(RUN_LEN - 1)) else $error("run count overflow");
  // slow rate stays low for the eight cycles after each pulse
  AST_DIV128_SOLO: assert property (@(posedge clk) disable iff (rst)
    en128 |=> !en128 [*8]) else $error("divide by 128 too fast");
endmodule

// ### testbench/sild_src.sv
// Board-side shutdown request sources driving the pins
module sild_src
  import sild_pkg::*;
(
  input wire logic clk,
  input wire logic [2:0] lvl,
  output sild_pins_s pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Lines launched off the clock, like a real board
  always_ff @(posedge clk) begin
    pins <= lvl;
  end
endmodule

// ### testbench/sild_top_tb.sv
// Self-checking bench for the shutdown input level detector
`include "sild_params.svh"
module sild_top_tb;
  import sild_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RL = 4;
  logic clk, rst, awv, wv, bry, arv, rry, awr, wr_rdy, bv, arr, rv, irq;
  logic [3:0] awa, ara, wst;
  logic [31:0] wd, rdat, rdd;
  logic [1:0] br, rr, rrsp, wrsp;
  logic [2:0] lvl, acc;
  sild_pins_s pins;
  int fails = 0, total_checks = 0, cyc = 0;
  sild_src sild_src_i (.clk(clk), .lvl(lvl), .pins(pins));
  sild_top #(.RUN_LEN(RL)) sild_top_i (.clk(clk), .rst(rst), .pins(pins),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .irq(irq), .accept(acc));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic finish_test();
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far above the slowest mode
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
    end while (bv !== 1'b1);
    wrsp = br;
    bry <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    ara <= a; arv <= 1; rry <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (rv !== 1'b1);
    rdat = rdd; rrsp = rr; rry <= 0;
  endtask
  // Waits for an accept pulse and judges its latency
  task automatic lat(input int i, input int lo, input int hi);
    int n;
    n = 0;
    while (acc[i] !== 1'b1 && n <= hi) begin
      @(posedge clk);
      n++;
    end
    chk("accept latency ok", n >= lo && n <= hi, 1);
  endtask
  task automatic t_regs();
    rd(`SILD_ADDR_MODE); chk("mode reset", rdat, 0);
    // Bits 1:0 are unused and read zero
    wr(`SILD_ADDR_MODE, 32'hff); chk("mode wr resp", wrsp, 0);
    rd(`SILD_ADDR_MODE); chk("mode rw", rdat, 32'hfc);
    wr(4'h2, 32'h0); chk("unmapped wr resp", wrsp, 2);
    wr(`SILD_ADDR_MODE, 0);
    rd(4'h2); chk("unmapped resp", rrsp, 2); chk("unmapped data", rdat, 0);
  endtask
  task automatic t_edge();
    wr(`SILD_ADDR_MASK, 7);
    lvl[2] <= 0;
    lat(2, 2, 8);
    repeat (3) @(posedge clk);
    chk("irq disabled", irq, 0);
    rd(`SILD_ADDR_STAT); chk("stat edge", rdat, 4);
    wr(`SILD_ADDR_IEN, 1); repeat (2) @(posedge clk); chk("irq enabled", irq, 1);
    lvl[2] <= 1;
    wr(`SILD_ADDR_STAT, 4); repeat (2) @(posedge clk); chk("irq cleared", irq, 0);
  endtask
  task automatic t_restart();
    wr(`SILD_ADDR_MODE, 32'h04);
    lvl[0] <= 0; repeat (16) @(posedge clk);
    lvl[0] <= 1; repeat (16) @(posedge clk);
    // A broken run must not qualify
    rd(`SILD_ADDR_STAT); chk("broken run", rdat, 0);
    lvl[0] <= 0;
    lat(0, (RL - 1) * 8, (RL + 1) * 8 + 8);
    lvl[0] <= 1; repeat (24) @(posedge clk);
    wr(`SILD_ADDR_STAT, 7);
  endtask
  task automatic t_modes();
    int dv[3] = '{`SILD_DIV8, `SILD_DIV16, `SILD_DIV128};
    for (int m = 1; m < 4; m++) begin
      wr(`SILD_ADDR_MODE, m << 4);
      lvl[1] <= 0;
      lat(1, (RL - 1) * dv[m-1], (RL + 1) * dv[m-1] + 8);
      lvl[1] <= 1; repeat (3 * dv[m-1]) @(posedge clk);
      wr(`SILD_ADDR_STAT, 7);
    end
  endtask
  initial begin
    rst = 1; lvl = 3'b111; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0;
    awa = 0; ara = 0; wd = 0; wst = 4'hf;
    repeat (20) @(posedge clk);
    rst <= 0;
    t_regs();
    t_edge();
    t_restart();
    t_modes();
    finish_test();
  end
endmodule
